// File: hw/csc_pkg.sv
// constants, register map and carrier types of the constant-speed step command engine
// assumes one 40 MHz clock and an Avalon-MM master with 32-bit data

package csc_pkg;

    // ------------------------------------------------------------
    // clocking and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int INT_BASE_HZ = 25000;
    localparam int BOARD_BASE_HZ = 800000;
    localparam int INT_TICK_CYC = CLK_HZ / INT_BASE_HZ;
    localparam int BOARD_TICK_CYC = CLK_HZ / BOARD_BASE_HZ;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_AXIS = 8'h00;
    localparam logic [7:0] OFS_SPEED = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_GO = 8'h0c;
    localparam logic [7:0] OFS_RESULT = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_CLKSRC = 8'h18;
    localparam logic [7:0] OFS_DIVIDER = 8'h1c;
    localparam logic [7:0] OFS_INIT = 8'h20;
    localparam logic [7:0] OFS_ACCEL = 8'h24;
    localparam logic [7:0] OFS_REMAIN0 = 8'h28;

    // ------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------
    localparam int STAT_BUSY_LSB = 0;
    localparam int STAT_DIR_LSB = 4;
    localparam int STAT_INIT_LSB = 8;
    localparam logic [1:0] CLKSRC_RST = 2'h0;
    localparam logic [7:0] DIVIDER_RST = 8'h00;
    localparam logic [7:0] ACCEL_RST = 8'h00;
    localparam logic [2:0] INIT_RST = 3'h0;

    // ------------------------------------------------------------
    // limits and encodings
    // ------------------------------------------------------------
    localparam logic [15:0] SPEED_MIN = 16'h0014;
    localparam logic [15:0] SPEED_MAX = 16'h00ff;
    localparam logic [31:0] COUNT_MAX = 32'h00ff_ffff;
    localparam logic [7:0] AXIS_COUNT = 8'h03;
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_BOARD = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;

    localparam logic [3:0] RES_OK = 4'h0;
    localparam logic [3:0] RES_BUSY = 4'h1;
    localparam logic [3:0] RES_UNINIT_A = 4'h2;
    localparam logic [3:0] RES_RANGE = 4'h7;
    localparam logic [3:0] RES_AXIS = 4'ha;
    localparam logic [3:0] RES_SPEED = 4'hb;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CSC_IDLE = 3'h1,
        CSC_SETUP = 3'h2,
        CSC_RUN = 3'h4
    } csc_state_t;

    typedef struct packed {
        logic jog;
        logic dir_cw;
        logic [23:0] count;
        logic [7:0] divisor;
    } csc_cmd_t;

endpackage : csc_pkg

// File: hw/csc_step_engine.sv
// three-axis constant-speed step command engine with an avalon-mm register slave
// assumes synchronous inputs, one 40 MHz clock and a stepper driver on o_step and o_dir
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module csc_step_engine #(
    parameter int AXES = 3
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // external step clock
    input wire logic i_ext_clock,
    // driver stage
    output logic [AXES-1:0] o_step,
    output logic [AXES-1:0] o_dir
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [7:0] axis_reg;
    logic [15:0] speed_reg;
    logic [31:0] count_reg;
    logic [3:0] result_reg;
    logic [1:0] clksrc_reg;
    logic [7:0] divider_reg;
    logic [2:0] init_reg;
    logic [7:0] accel_reg;
    logic ext_prev_reg;
    logic [15:0] int_cnt_reg;
    logic [7:0] board_cnt_reg;
    logic [7:0] xdiv_cnt_reg;
    logic int_tick_reg;
    logic board_tick_reg;

    logic [AXES-1:0] busy;
    logic [AXES-1:0] start;
    logic [23:0] remain [AXES];
    logic acc;
    logic go;
    logic base_tick;
    logic [31:0] mag;
    logic [3:0] result_next;
    logic start_ok;
    csc_pkg::csc_cmd_t cmd;

    assign acc = (i_read || i_write) && !wait_reg;
    assign go = acc && i_write && (i_address == csc_pkg::OFS_GO);

    // ------------------------------------------------------------
    // bus handshake: one wait cycle, then waitrequest low for one cycle
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wait_reg <= 1'b1;
        end else if ((i_read || i_write) && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    assign o_waitrequest = wait_reg;

    // ------------------------------------------------------------
    // status word: busy, direction and init bits per axis
    // ------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] remain_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[csc_pkg::STAT_BUSY_LSB +: AXES] = busy;
        status_word[csc_pkg::STAT_DIR_LSB +: AXES] = o_dir;
        status_word[csc_pkg::STAT_INIT_LSB +: 3] = init_reg;
    end

    // ------------------------------------------------------------
    // remaining step count of the addressed axis
    // ------------------------------------------------------------
    always_comb begin
        remain_word = 32'h0000_0000;
        for (int k = 0; k < AXES; k++) begin
            if (i_address == csc_pkg::OFS_REMAIN0 + 8'(4 * k)) begin
                remain_word = {8'h00, remain[k]};
            end
        end
    end

    // ------------------------------------------------------------
    // read data, loaded as waitrequest drops
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (i_read && wait_reg) begin
            rdata_reg <= 32'h0000_0000;
            case (i_address)
                csc_pkg::OFS_AXIS: rdata_reg <= {24'h00_0000, axis_reg};
                csc_pkg::OFS_SPEED: rdata_reg <= {16'h0000, speed_reg};
                csc_pkg::OFS_COUNT: rdata_reg <= count_reg;
                csc_pkg::OFS_RESULT: rdata_reg <= {28'h000_0000, result_reg};
                csc_pkg::OFS_STATUS: rdata_reg <= status_word;
                csc_pkg::OFS_CLKSRC: rdata_reg <= {30'h0000_0000, clksrc_reg};
                csc_pkg::OFS_DIVIDER: rdata_reg <= {24'h00_0000, divider_reg};
                csc_pkg::OFS_INIT: rdata_reg <= {29'h0000_0000, init_reg};
                csc_pkg::OFS_ACCEL: rdata_reg <= {24'h00_0000, accel_reg};
                default: rdata_reg <= remain_word;
            endcase
        end
    end

    assign o_readdata = rdata_reg;

    // ------------------------------------------------------------
    // command parameter registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            axis_reg <= 8'h00;
            speed_reg <= 16'h0000;
            count_reg <= 32'h0000_0000;
        end else if (acc && i_write) begin
            if (i_address == csc_pkg::OFS_AXIS) begin
                axis_reg <= i_writedata[7:0];
            end
            if (i_address == csc_pkg::OFS_SPEED) begin
                speed_reg <= i_writedata[15:0];
            end
            if (i_address == csc_pkg::OFS_COUNT) begin
                count_reg <= i_writedata;
            end
        end
    end

    // ------------------------------------------------------------
    // board configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            clksrc_reg <= csc_pkg::CLKSRC_RST;
            divider_reg <= csc_pkg::DIVIDER_RST;
            init_reg <= csc_pkg::INIT_RST;
            accel_reg <= csc_pkg::ACCEL_RST;
        end else if (acc && i_write) begin
            if (i_address == csc_pkg::OFS_CLKSRC) begin
                clksrc_reg <= i_writedata[1:0];
            end
            if (i_address == csc_pkg::OFS_DIVIDER) begin
                divider_reg <= i_writedata[7:0];
            end
            if (i_address == csc_pkg::OFS_INIT) begin
                init_reg <= i_writedata[2:0];
            end
            if (i_address == csc_pkg::OFS_ACCEL) begin
                accel_reg <= i_writedata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // command check flags, one per refusal, and the decoded jog, direction and step count
    // ------------------------------------------------------------
    logic [1:0] sel_axis;
    logic bad_axis;
    logic bad_speed;
    logic bad_range;
    logic not_init;
    logic axis_busy;
    logic zero_count;
    logic one_step;
    logic pos_dir;
    logic [23:0] load_count;

    assign sel_axis = axis_reg[1:0];

    always_comb begin
        mag = count_reg[31] ? 32'(-count_reg) : count_reg;
        bad_axis = (axis_reg >= csc_pkg::AXIS_COUNT);
        bad_speed = (speed_reg < csc_pkg::SPEED_MIN) || (speed_reg > csc_pkg::SPEED_MAX);
        bad_range = (mag > csc_pkg::COUNT_MAX);
        not_init = !init_reg[sel_axis];
        axis_busy = busy[sel_axis];
        zero_count = (mag == 32'h0000_0000);
        one_step = (mag == 32'h0000_0001);
        pos_dir = !count_reg[31];
        load_count = 24'(mag - 32'h0000_0001);
    end

    // ------------------------------------------------------------
    // command checks and result code
    // ------------------------------------------------------------
    always_comb begin
        result_next = csc_pkg::RES_OK;
        start_ok = 1'b0;
        if (bad_axis) begin
            result_next = csc_pkg::RES_AXIS;
        end else if (bad_speed) begin
            result_next = csc_pkg::RES_SPEED;
        end else if (bad_range) begin
            result_next = csc_pkg::RES_RANGE;
        end else if (not_init) begin
            result_next = csc_pkg::RES_UNINIT_A + 4'(sel_axis);
        end else if (axis_busy) begin
            result_next = csc_pkg::RES_BUSY;
        end else if (!zero_count) begin
            start_ok = 1'b1;
        end
    end

    always_comb begin
        cmd.jog = one_step;
        cmd.dir_cw = pos_dir;
        cmd.count = load_count;
        cmd.divisor = speed_reg[7:0];
    end

    always_comb begin
        for (int k = 0; k < AXES; k++) begin
            start[k] = go && start_ok && (axis_reg[1:0] == 2'(k));
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            result_reg <= csc_pkg::RES_OK;
        end else if (go) begin
            result_reg <= result_next;
        end
    end

    // ------------------------------------------------------------
    // internal 25 kHz base
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            int_cnt_reg <= 16'h0000;
            int_tick_reg <= 1'b0;
        end else if (int_cnt_reg == 16'(csc_pkg::INT_TICK_CYC - 1)) begin
            int_cnt_reg <= 16'h0000;
            int_tick_reg <= 1'b1;
        end else begin
            int_cnt_reg <= int_cnt_reg + 16'h0001;
            int_tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // on-board 800 kHz base through the divider ratio
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            board_cnt_reg <= 8'h00;
            xdiv_cnt_reg <= 8'h00;
            board_tick_reg <= 1'b0;
        end else begin
            board_tick_reg <= 1'b0;
            if (board_cnt_reg == 8'(csc_pkg::BOARD_TICK_CYC - 1)) begin
                board_cnt_reg <= 8'h00;
                if (xdiv_cnt_reg >= divider_reg) begin
                    xdiv_cnt_reg <= 8'h00;
                    board_tick_reg <= 1'b1;
                end else begin
                    xdiv_cnt_reg <= xdiv_cnt_reg + 8'h01;
                end
            end else begin
                board_cnt_reg <= board_cnt_reg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // external clock edge
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= i_ext_clock;
        end
    end

    logic ext_rise;

    assign ext_rise = i_ext_clock && !ext_prev_reg;

    always_comb begin
        case (clksrc_reg)
            csc_pkg::SRC_INTERNAL: base_tick = int_tick_reg;
            csc_pkg::SRC_BOARD: base_tick = board_tick_reg;
            csc_pkg::SRC_EXTERNAL: base_tick = ext_rise;
            default: base_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // per-axis step generators
    // ------------------------------------------------------------
    for (genvar g = 0; g < AXES; g++) begin : gen_axis
        csc_pkg::csc_state_t state_reg;
        csc_pkg::csc_cmd_t cmd_reg;
        logic [7:0] rate_cnt_reg;
        logic step_reg;
        logic dir_reg;
        logic rate_done;

        assign rate_done = (rate_cnt_reg == cmd_reg.divisor - 8'h01);

        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                state_reg <= csc_pkg::CSC_IDLE;
                cmd_reg <= '0;
                rate_cnt_reg <= 8'h00;
                step_reg <= 1'b0;
                dir_reg <= 1'b0;
            end else begin
                step_reg <= 1'b0;
                case (state_reg)
                    csc_pkg::CSC_IDLE: begin
                        if (start[g]) begin
                            cmd_reg <= cmd;
                            dir_reg <= cmd.dir_cw;
                            rate_cnt_reg <= 8'h00;
                            state_reg <= csc_pkg::CSC_SETUP;
                        end
                    end
                    csc_pkg::CSC_SETUP: begin
                        if (cmd_reg.jog) begin
                            step_reg <= 1'b1;
                            state_reg <= csc_pkg::CSC_IDLE;
                        end else begin
                            state_reg <= csc_pkg::CSC_RUN;
                        end
                    end
                    csc_pkg::CSC_RUN: begin
                        if (base_tick) begin
                            if (rate_done) begin
                                rate_cnt_reg <= 8'h00;
                                step_reg <= 1'b1;
                                if (cmd_reg.count == 24'h00_0000) begin
                                    state_reg <= csc_pkg::CSC_IDLE;
                                end else begin
                                    cmd_reg.count <= cmd_reg.count - 24'h00_0001;
                                end
                            end else begin
                                rate_cnt_reg <= rate_cnt_reg + 8'h01;
                            end
                        end
                    end
                    default: state_reg <= csc_pkg::CSC_IDLE;
                endcase
            end
        end

        assign busy[g] = (state_reg != csc_pkg::CSC_IDLE);
        assign remain[g] = cmd_reg.count;
        assign o_step[g] = step_reg;
        assign o_dir[g] = dir_reg;
    end

endmodule : csc_step_engine

`default_nettype wire

// File: sim/csc_drv_model.sv
// driver stage model: counts steps per axis and times the spacing between them
// assumes one-cycle step pulses and a direction level that is 1 for clockwise
`timescale 1ns/1ps
`default_nettype none
module csc_drv_model (
    // clock
    input wire logic i_clock,
    // step and direction lines
    input wire logic [2:0] i_step,
    input wire logic [2:0] i_dir,
    // signed position and last step spacing in clocks, per axis
    output int o_pos [3],
    output int o_gap [3]
);
    int now = 0;
    int last [3] = '{0, 0, 0};
    initial begin
        o_pos = '{0, 0, 0};
        o_gap = '{0, 0, 0};
    end
    always @(posedge i_clock) begin
        now++;
        for (int k = 0; k < 3; k++) begin
            if (i_step[k] === 1'b1) begin
                o_pos[k] += (i_dir[k] === 1'b1) ? 1 : -1;
                o_gap[k] = now - last[k];
                last[k] = now;
            end
        end
    end
endmodule : csc_drv_model
`default_nettype wire

// File: sim/csc_step_engine_properties.sv
// concurrent checks on the engine's bus and driver stage ports
// assumes a bind into csc_step_engine, one clock, asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module csc_step_engine_properties #(
    parameter int AXES = 3
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    // driver stage
    input wire logic [AXES-1:0] o_step,
    input wire logic [AXES-1:0] o_dir
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic go_d1;
    logic go_d2;
    // go write delayed by one and two cycles
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            go_d1 <= 1'b0;
            go_d2 <= 1'b0;
        end else begin
            go_d1 <= i_write && !o_waitrequest && i_address == 8'h0c;
            go_d2 <= go_d1;
        end
    end
    a_wait_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("bus request not answered one cycle later");
    a_wait_single: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle: assert property (!(i_read || i_write) |=> o_waitrequest)
        else $error("waitrequest low without a request");
    a_unmapped_zero: assert property (i_read && !o_waitrequest
        && (i_address > 8'h30 || i_address == 8'h0c) |-> o_readdata == 32'h0)
        else $error("unmapped or go read not zero");
    a_step_pulse: assert property ((o_step & $past(o_step)) == '0)
        else $error("step pulse longer than one cycle");
    a_step_spacing: assert property (o_step[0] |=> (!o_step[0]) [*8])
        else $error("steps on axis a too close");
    a_dir_cause: assert property (o_dir != $past(o_dir) |-> go_d1 || go_d2)
        else $error("direction changed without a go write");
    a_dir_before_step: assert property ((o_step & (o_dir ^ $past(o_dir))) == '0)
        else $error("direction changed with a step pulse");
    a_reset_quiet: assert property (disable iff (1'b0)
        i_rst && $past(i_rst) |-> o_step == '0 && o_dir == '0 && o_waitrequest)
        else $error("outputs active during reset");
endmodule : csc_step_engine_properties
`default_nettype wire

// File: sim/tb.sv
// self-checking bench: register access, command results, step counts and rates
// assumes the package, engine, checker and driver stage model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_address = 8'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic i_ext_clock = 1'b0;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic [2:0] o_step;
    logic [2:0] o_dir;
    int pos [3];
    int gap [3];
    int errors = 0;
    int comparisons = 0;
    int p;
    logic [31:0] q;
    csc_step_engine #(.AXES(3)) i_dut (.i_clock(i_clock), .i_rst(i_rst),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_ext_clock(i_ext_clock), .o_step(o_step), .o_dir(o_dir));
    csc_drv_model i_drv (.i_clock(i_clock), .i_step(o_step), .i_dir(o_dir),
        .o_pos(pos), .o_gap(gap));
    initial begin
        forever #12.5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) i_ext_clock <= ~i_ext_clock;
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        i_write <= wr;
        i_read <= !wr;
        i_address <= a;
        i_writedata <= d;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 40);
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        if (n >= 40) check("waitrequest", 32'h1, 32'h0);
        @(posedge i_clock);
    endtask : bus
    task automatic cmd(input logic [7:0] ax, input logic [15:0] sp, input logic [31:0] c);
        bus(1'b1, 8'h00, {24'h0, ax});
        bus(1'b1, 8'h04, {16'h0, sp});
        bus(1'b1, 8'h08, c);
        bus(1'b1, 8'h0c, 32'h1);
        bus(1'b0, 8'h10, 32'h0);
    endtask : cmd
    task automatic try(input logic [7:0] ax, input logic [15:0] sp, input logic [31:0] c,
            input logic [3:0] e);
        cmd(ax, sp, c);
        check("result", q, {28'h0, e});
    endtask : try
    task automatic wait_idle();
        int n = 0;
        do begin
            bus(1'b0, 8'h14, 32'h0);
            n++;
        end while (q[2:0] !== 3'h0 && n < 40000);
        if (q[2:0] !== 3'h0) check("idle", 32'h1, 32'h0);
    endtask : wait_idle
    function automatic logic [3:0] exp_res(input logic [7:0] ax, input logic [15:0] sp,
            input logic [31:0] c, input logic [2:0] ini, input logic [2:0] bsy);
        logic [31:0] m;
        m = c[31] ? -c : c;
        if (ax > 8'h02) return 4'ha;
        if (sp < 16'h0014 || sp > 16'h00ff) return 4'hb;
        if (m > 32'h00ff_ffff) return 4'h7;
        if (!ini[ax[1:0]]) return 4'h2 + ax[3:0];
        if (bsy[ax[1:0]]) return 4'h1;
        return 4'h0;
    endfunction : exp_res
    task automatic stop_test();
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (95000) @(posedge i_clock);
        errors++;
        stop_test();
    end
    initial begin
        logic [7:0] ax;
        logic [15:0] sp;
        logic [31:0] c;
        void'($urandom(45257));
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        // reset values, write-only and unmapped places
        bus(1'b1, 8'h40, 32'h5a5a_5a5a);
        for (int k = 0; k < 7; k++) begin
            bus(1'b0, {k[4:0], 3'h0} + 8'h0c, 32'h0);
            check("reset read", q, 32'h0);
        end
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped", q, 32'h0);
        // refusals
        for (int k = 0; k < 3; k++) begin
            try(k[7:0], 16'h0014, 32'h5, 4'h2 + k[3:0]);
        end
        try(8'h03, 16'h0014, 32'h5, 4'ha);
        try(8'h00, 16'h0013, 32'h5, 4'hb);
        try(8'h00, 16'h0100, 32'h5, 4'hb);
        try(8'h01, 16'h00ff, 32'h00ff_ffff, 4'h3);
        try(8'h01, 16'h0014, 32'h0100_0000, 4'h7);
        try(8'h01, 16'h0014, 32'hff00_0000, 4'h7);
        repeat (16) begin
            ax = 8'($urandom_range(32'h4));
            sp = 16'($urandom_range(32'h12c));
            c = $urandom | 32'h0100_0000;
            if (ax[0]) c = 32'h0;
            try(ax, sp, c, exp_res(ax, sp, c, 3'h0, 3'h0));
        end
        // external clock, busy refusal, chaining, jog and zero count
        bus(1'b1, 8'h20, 32'h7);
        bus(1'b1, 8'h24, 32'h5a);
        bus(1'b1, 8'h18, 32'h2);
        try(8'h00, 16'h0019, 32'h4, 4'h0);
        try(8'h00, 16'h0019, 32'h4, 4'h1);
        bus(1'b0, 8'h14, 32'h0);
        check("status", q, 32'h0000_0711);
        wait_idle();
        check("pos a", pos[0], 32'h4);
        check("gap a", gap[0], 32'h32);
        try(8'h01, 16'h0014, 32'h5, 4'h0);
        do cmd(8'h01, 16'h0014, 32'hffff_fffe); while (q[3:0] === 4'h1);
        check("chain", q, 32'h0);
        wait_idle();
        check("pos b", pos[1], 32'h3);
        check("gap b", gap[1], 32'h28);
        try(8'h02, 16'h0014, 32'hffff_ffff, 4'h0);
        wait_idle();
        try(8'h02, 16'h0014, 32'h0, 4'h0);
        bus(1'b0, 8'h14, 32'h0);
        check("status", q, 32'h0000_0710);
        check("pos c", pos[2], 32'hffff_ffff);
        try(8'h01, 16'h00ff, 32'h2, 4'h0);
        wait_idle();
        check("gap max", gap[1], 32'h1fe);
        check("pos b", pos[1], 32'h5);
        // on-board clock with live divider
        bus(1'b1, 8'h18, 32'h1);
        bus(1'b1, 8'h1c, 32'h0);
        try(8'h00, 16'h0014, 32'h3, 4'h0);
        wait_idle();
        check("gap x0", gap[0], 32'h3e8);
        p = pos[0];
        try(8'h00, 16'h0014, 32'h4, 4'h0);
        for (int n = 0; n < 3000 && pos[0] == p; n++) @(posedge i_clock);
        bus(1'b1, 8'h1c, 32'h1);
        wait_idle();
        check("gap x1", gap[0], 32'h7d0);
        check("pos a", pos[0], 32'hb);
        // internal clock
        bus(1'b1, 8'h18, 32'h0);
        try(8'h01, 16'h0014, 32'h2, 4'h0);
        wait_idle();
        check("gap int", gap[1], 32'h7d00);
        bus(1'b0, 8'h24, 32'h0);
        check("accel", q, 32'h5a);
        stop_test();
    end
endmodule : tb
bind csc_step_engine csc_step_engine_properties #(.AXES(AXES)) i_props (
    .i_clock(i_clock), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_step(o_step), .o_dir(o_dir));
`default_nettype wire
